// ---- inc/txp_pkg.sv ----
// Constants and types for the transmit buffer command parser.
// Assumes a single clock domain and an APB register port with 32-bit data.
// What this block does
// RULE1 - Copy packet tag into status word
// RULE2 - Host writes zero to reserved bit
// RULE3 - Checksum only with request, first segment, enable
// RULE4 - CRC disable bit suppresses automatic CRC
// RULE5 - Pad disable stops padding, CRC still added
// RULE6 - Length mismatch sets transmit error flag
// RULE7 - Data section follows the command words
// RULE8 - Low offset bits pick first data lane
// RULE9 - Skip whole offset words before data
// RULE10 - Drop unused trailing lanes of last word
// RULE11 - Host pads to alignment, device discards it
// RULE12 - Middle buffers hold at least four bytes
// RULE13 - Accept any alignment and end lengths
// RULE14 - Host keeps packet within FIFO space limit
// RULE15 - Store only partial ends and whole words
// RULE16 - Host may cap packet at 86 buffers
// RULE17 - First and last segment flags mark position
// RULE18 - Start offset from first command word
// RULE19 - Buffer size sizes padding and length sum
// RULE20 - Second command word only on first segment
package txp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_TX_DATA   = 8'h00;
    localparam logic [7:0] OFF_CTRL      = 8'h04;
    localparam logic [7:0] OFF_STATUS    = 8'h08;
    localparam logic [7:0] OFF_LAST_STAT = 8'h0C;
    // Register fields and reset values
    localparam int unsigned CTRL_CSUM_EN_BIT = 0;
    localparam int unsigned STAT_TXERR_BIT   = 0;
    localparam int unsigned STAT_INPKT_BIT   = 1;
    localparam logic        CTRL_CSUM_RESET  = 1'b0;
    // First command word
    localparam int unsigned A_ALIGN_LO = 24;
    localparam int unsigned A_OFF_LO   = 16;
    localparam int unsigned A_FS_BIT   = 13;
    localparam int unsigned A_LS_BIT   = 12;
    localparam int unsigned A_SIZE_LO  = 0;
    // Second command word
    localparam int unsigned B_TAG_LO      = 16;
    localparam int unsigned B_CSUM_BIT    = 14;
    localparam int unsigned B_CRC_DIS_BIT = 13;
    localparam int unsigned B_PAD_DIS_BIT = 12;
    localparam int unsigned B_LEN_LO      = 0;
    // Status word error bit
    localparam int unsigned ST_ERR_BIT = 15;

    typedef enum logic [1:0] {
        ALIGN_4    = 2'b00,
        ALIGN_16   = 2'b01,
        ALIGN_32   = 2'b10,
        ALIGN_RSVD = 2'b11
    } align_t;

    typedef enum logic [2:0] {
        P_CMD_A = 3'b001,
        P_CMD_B = 3'b010,
        P_DATA  = 3'b100
    } parse_state_t;
endpackage

// ---- design/buf_span_calc.sv ----
// Span arithmetic for one transmit buffer, purely combinational.
// Assumes inputs are the raw fields of the first command word.
`timescale 1ns/1ps
module buf_span_calc (
    // Command fields
    input  wire logic [4:0]  start_off,
    input  wire logic [10:0] size,
    input  wire logic [1:0]  align,
    // Word counts and lane masks
    output logic      [2:0]  skip_words,
    output logic      [10:0] data_words,
    output logic      [10:0] total_words,
    output logic      [3:0]  first_mask,
    output logic      [3:0]  last_mask
);
    logic [12:0] amask;
    logic [12:0] end_b;
    logic [12:0] round_b;
    logic [12:0] lane_end;

    // Any start byte and any length are legal, ends included [RULE13]
    always_comb begin
        unique case (txp_pkg::align_t'(align))
            txp_pkg::ALIGN_16: amask = 13'h000F;
            txp_pkg::ALIGN_32: amask = 13'h001F;
            default:           amask = 13'h0003; // Reserved code treated as 4
        endcase
        end_b       = {8'h00, start_off} + {2'h0, size};
        round_b     = (end_b + amask) & ~amask;  // Host padding to alignment [RULE11]
        total_words = round_b[12:2];
        lane_end    = {11'h000, start_off[1:0]} + {2'h0, size} + 13'h0003;
        data_words  = (size == 11'h000) ? 11'h000 : lane_end[12:2];
        skip_words  = start_off[4:2];             // Whole offset words [RULE9]
        first_mask  = 4'hF << start_off[1:0];     // First valid lane [RULE8]
        // Trailing unused lanes are masked off [RULE10]
        unique case (end_b[1:0])
            2'h1:    last_mask = 4'h1;
            2'h2:    last_mask = 4'h3;
            2'h3:    last_mask = 4'h7;
            default: last_mask = 4'hF;
        endcase
    end
endmodule // buf_span_calc

// ---- design/mac_out_stage.sv ----
// One-word holding stage toward the MAC transmit path.
// Assumes the feeder pushes only while the stage is empty.
`timescale 1ns/1ps
module mac_out_stage (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // Feed side
    input  wire logic        push,
    input  wire logic [31:0] word,
    input  wire logic [3:0]  lanes,
    input  wire logic        sof,
    input  wire logic        eof,
    // MAC side
    input  wire logic        mac_ready,
    output logic             mac_valid,
    output logic      [31:0] mac_data,
    output logic      [3:0]  mac_lanes,
    output logic             mac_sof,
    output logic             mac_eof
);
    // Valid drops once the MAC takes the word
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mac_valid <= 1'b0;
        end else if (push) begin
            mac_valid <= 1'b1;
        end else if (mac_ready) begin
            mac_valid <= 1'b0;
        end
    end

    // Payload held until the next push
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mac_data  <= 32'h0000_0000;
            mac_lanes <= 4'h0;
            mac_sof   <= 1'b0;
            mac_eof   <= 1'b0;
        end else if (push) begin
            mac_data  <= word;
            mac_lanes <= lanes;
            mac_sof   <= sof;
            mac_eof   <= eof;
        end
    end
endmodule // mac_out_stage

// ---- design/tx_buffer_command_parser.sv ----
// Transmit buffer parser: APB word port in, lane-masked words out to the MAC.
// Assumes the host follows the buffer fragmentation limits of the FIFO.
`timescale 1ns/1ps
module tx_buffer_command_parser #(
    parameter int unsigned SUM_W = 18
) (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // APB slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // MAC transmit path
    input  wire logic        mac_ready,
    output logic             mac_valid,
    output logic      [31:0] mac_data,
    output logic      [3:0]  mac_lanes,
    output logic             mac_sof,
    output logic             mac_eof,
    // Per-frame controls
    output logic             frame_crc_add,
    output logic             frame_pad_en,
    output logic             frame_csum_en,
    // Packet status
    output logic      [31:0] status_word,
    output logic             status_valid
);
    if (SUM_W < 12) begin : g_sum_w_check
        $error("SUM_W too small for one packet length");
    end

    // Register hit, one-hot: data, control, status, last status
    function automatic logic [3:0] reg_hit(input logic [7:0] a);
        reg_hit = {a == txp_pkg::OFF_LAST_STAT, a == txp_pkg::OFF_STATUS,
                   a == txp_pkg::OFF_CTRL, a == txp_pkg::OFF_TX_DATA};
    endfunction

    txp_pkg::parse_state_t state_r;
    logic [3:0]       hit;
    logic             access;
    logic             done;
    logic             word_push;
    logic             push_a;
    logic             push_b;
    logic             push_d;
    logic             ctrl_csum_en_r;
    logic             txerr_r;
    logic             in_pkt_r;
    logic [31:0]      last_stat_r;
    logic [2:0]       skip_new;
    logic [10:0]      dw_new;
    logic [10:0]      tot_new;
    logic [3:0]       fmask_new;
    logic [3:0]       lmask_new;
    logic [2:0]       skip_r;
    logic [10:0]      dw_r;
    logic [10:0]      tot_r;
    logic [3:0]       fmask_r;
    logic [3:0]       lmask_r;
    logic [10:0]      idx_r;
    logic [10:0]      rel;
    logic             fs_r;
    logic             ls_r;
    logic             sof_pend_r;
    logic [15:0]      tag_r;
    logic [10:0]      len_r;
    logic [SUM_W-1:0] sum_r;
    logic [SUM_W-1:0] sum_nxt;
    logic             a_fs;
    logic             a_ls;
    logic             b_csum;
    logic             b_crc_dis;
    logic             b_pad_dis;
    logic             ls_cur;
    logic             buf_end;
    logic             pkt_end;
    logic             len_mismatch;
    logic             fwd;
    logic [3:0]       fwd_mask;

    // Bus decode; writes take effect on the completing edge, read data is loaded one edge before it
    assign hit       = reg_hit(paddr);
    assign access    = psel & penable;
    assign done      = access & pready;
    assign word_push = done & pwrite & hit[0];
    assign push_a    = word_push & (state_r == txp_pkg::P_CMD_A);
    assign push_b    = word_push & (state_r == txp_pkg::P_CMD_B);
    assign push_d    = word_push & (state_r == txp_pkg::P_DATA);

    // Ready comes one wait state late; data writes also wait for an empty stage
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (pready) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (access && !(hit[0] && pwrite && mac_valid)) begin
            pready  <= 1'b1;
            pslverr <= (hit == 4'h0);
        end
    end

    // Read data captured with ready; data port and unmapped read zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (access && !pready && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (hit[1]) prdata[txp_pkg::CTRL_CSUM_EN_BIT] <= ctrl_csum_en_r;
            if (hit[2]) begin
                prdata[txp_pkg::STAT_TXERR_BIT] <= txerr_r;
                prdata[txp_pkg::STAT_INPKT_BIT] <= in_pkt_r;
            end
            if (hit[3]) prdata <= last_stat_r;
        end
    end

    // Checksum engine enable steers frame_csum_en
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl_csum_en_r <= txp_pkg::CTRL_CSUM_RESET;
        end else if (done && pwrite && hit[1]) begin
            ctrl_csum_en_r <= pwdata[txp_pkg::CTRL_CSUM_EN_BIT];
        end
    end

    // Error flag: a new mismatch beats a write-one-to-clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            txerr_r <= 1'b0;
        end else if (pkt_end && len_mismatch) begin
            txerr_r <= 1'b1; // [RULE6]
        end else if (done && pwrite && hit[2] && pwdata[txp_pkg::STAT_TXERR_BIT]) begin
            txerr_r <= 1'b0;
        end
    end

    // Command field views
    assign a_fs      = pwdata[txp_pkg::A_FS_BIT];  // [RULE17]
    assign a_ls      = pwdata[txp_pkg::A_LS_BIT];  // [RULE17]
    assign b_csum    = pwdata[txp_pkg::B_CSUM_BIT];
    assign b_crc_dis = pwdata[txp_pkg::B_CRC_DIS_BIT];
    assign b_pad_dis = pwdata[txp_pkg::B_PAD_DIS_BIT];

    buf_span_calc u_span (
        .start_off   (pwdata[txp_pkg::A_OFF_LO +: 5]), // [RULE18]
        .size        (pwdata[txp_pkg::A_SIZE_LO +: 11]),
        .align       (pwdata[txp_pkg::A_ALIGN_LO +: 2]),
        .skip_words  (skip_new),
        .data_words  (dw_new),
        .total_words (tot_new),
        .first_mask  (fmask_new),
        .last_mask   (lmask_new)
    );

    // Buffer and packet ends, including buffers with no data words
    assign ls_cur  = push_a ? a_ls : ls_r;
    assign buf_end = (push_a && !a_fs && tot_new == 11'h000) || (push_b && tot_r == 11'h000)
                   || (push_d && idx_r == tot_r - 11'h001);
    assign pkt_end = buf_end && ls_cur;

    // Running size sum; first segment restarts it [RULE19]
    always_comb begin
        sum_nxt = sum_r;
        if (push_a) begin
            sum_nxt = (a_fs ? '0 : sum_r) + SUM_W'(pwdata[txp_pkg::A_SIZE_LO +: 11]);
        end
    end
    assign len_mismatch = sum_nxt != SUM_W'(push_b ? pwdata[txp_pkg::B_LEN_LO +: 11] : len_r); // [RULE6]

    // Parser state: second word only after a first segment [RULE20]
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_r <= txp_pkg::P_CMD_A;
        end else begin
            unique case (state_r)
                txp_pkg::P_CMD_A: begin
                    if (push_a) begin
                        if (a_fs) state_r <= txp_pkg::P_CMD_B;
                        else if (tot_new != 11'h000) state_r <= txp_pkg::P_DATA;
                    end
                end
                txp_pkg::P_CMD_B: begin
                    if (push_b) begin
                        // Data section starts right after the second word [RULE7]
                        state_r <= (tot_r == 11'h000) ? txp_pkg::P_CMD_A : txp_pkg::P_DATA;
                    end
                end
                txp_pkg::P_DATA: begin
                    if (buf_end) state_r <= txp_pkg::P_CMD_A;
                end
            endcase
        end
    end

    // Per-buffer span latched from the first command word
    always_ff @(posedge core_clk) begin
        if (srst) begin
            skip_r  <= 3'h0;
            dw_r    <= 11'h000;
            tot_r   <= 11'h000;
            fmask_r <= 4'hF;
            lmask_r <= 4'hF;
            fs_r    <= 1'b0;
            ls_r    <= 1'b0;
            sum_r   <= '0;
        end else if (push_a) begin
            skip_r  <= skip_new;
            dw_r    <= dw_new;
            tot_r   <= tot_new;
            fmask_r <= fmask_new;
            lmask_r <= lmask_new;
            fs_r    <= a_fs;
            ls_r    <= a_ls;
            sum_r   <= sum_nxt;
        end
    end

    // Word index within the buffer's data section
    always_ff @(posedge core_clk) begin
        if (srst) begin
            idx_r <= 11'h000;
        end else if (push_a || push_b) begin
            idx_r <= 11'h000;
        end else if (push_d) begin
            idx_r <= idx_r + 11'h001;
        end
    end

    // Packet fields from the second command word
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tag_r         <= 16'h0000;
            len_r         <= 11'h000;
            frame_crc_add <= 1'b1;
            frame_pad_en  <= 1'b1;
            frame_csum_en <= 1'b0;
        end else if (push_b) begin
            tag_r         <= pwdata[txp_pkg::B_TAG_LO +: 16];
            len_r         <= pwdata[txp_pkg::B_LEN_LO +: 11];
            frame_crc_add <= !b_crc_dis || b_pad_dis;     // [RULE4] [RULE5]
            frame_pad_en  <= !b_pad_dis;                  // [RULE5]
            frame_csum_en <= b_csum && ctrl_csum_en_r;    // First segment implied [RULE3]
        end
    end

    // Whole offset words and alignment padding never reach the stage
    assign rel = idx_r - {8'h00, skip_r};
    assign fwd = push_d && (idx_r >= {8'h00, skip_r}) && (rel < dw_r); // [RULE9] [RULE11] [RULE15]
    assign fwd_mask = (rel == 11'h000 ? fmask_r : 4'hF)               // [RULE8]
                    & (rel == dw_r - 11'h001 ? lmask_r : 4'hF);       // [RULE10]

    // Start-of-frame marker waits for the packet's first stored word
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sof_pend_r <= 1'b0;
        end else if (push_b) begin
            sof_pend_r <= 1'b1;
        end else if (fwd) begin
            sof_pend_r <= 1'b0;
        end
    end

    mac_out_stage u_out (
        .core_clk  (core_clk),
        .srst      (srst),
        .push      (fwd),
        .word      (pwdata),
        .lanes     (fwd_mask),
        .sof       (sof_pend_r),
        .eof       (ls_r && rel == dw_r - 11'h001),
        .mac_ready (mac_ready),
        .mac_valid (mac_valid),
        .mac_data  (mac_data),
        .mac_lanes (mac_lanes),
        .mac_sof   (mac_sof),
        .mac_eof   (mac_eof)
    );

    // Status word per packet: tag above, length error below [RULE1] [RULE6]
    always_ff @(posedge core_clk) begin
        if (srst) begin
            status_valid <= 1'b0;
            status_word  <= 32'h0000_0000;
            last_stat_r  <= 32'h0000_0000;
        end else begin
            status_valid <= pkt_end;
            if (pkt_end) begin
                status_word  <= {(push_b ? pwdata[txp_pkg::B_TAG_LO +: 16] : tag_r), len_mismatch, 15'h0000};
                last_stat_r  <= {(push_b ? pwdata[txp_pkg::B_TAG_LO +: 16] : tag_r), len_mismatch, 15'h0000};
            end
        end
    end

    // Packet in progress between first segment and packet end
    always_ff @(posedge core_clk) begin
        if (srst) begin
            in_pkt_r <= 1'b0;
        end else if (pkt_end) begin
            in_pkt_r <= 1'b0;
        end else if (push_a && a_fs) begin
            in_pkt_r <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_cmd_b_take;
        push_b && tot_r != 11'h000;
    endsequence
    sequence s_enter_data;
        state_r == txp_pkg::P_DATA && idx_r == 11'h000;
    endsequence

    a_tag_copy: assert property (status_valid |-> status_word[31:16] == tag_r) // [RULE1]
        else $error("status tag differs from packet tag");
    a_csum_gate: assert property (push_b |=> frame_csum_en == ($past(b_csum) && $past(ctrl_csum_en_r))) // [RULE3]
        else $error("checksum enable not gated correctly");
    a_crc_disable: assert property (push_b && b_crc_dis && !b_pad_dis |=> !frame_crc_add) // [RULE4]
        else $error("CRC added despite disable");
    a_pad_keeps_crc: assert property (push_b && b_pad_dis |=> frame_crc_add && !frame_pad_en) // [RULE5]
        else $error("pad disable handled wrongly");
    a_len_error: assert property (pkt_end && len_mismatch |=> txerr_r && status_word[txp_pkg::ST_ERR_BIT]) // [RULE6]
        else $error("length mismatch not flagged");
    a_data_after_b: assert property (s_cmd_b_take |=> s_enter_data) // [RULE7]
        else $error("data section not entered after second word");
    a_first_lane: assert property (fwd && rel == 11'h000 |=> mac_valid && (mac_lanes & ~$past(fmask_r)) == 4'h0) // [RULE8]
        else $error("lanes before start offset forwarded");
    a_skip_words: assert property (push_d && idx_r < {8'h00, skip_r} |=> !mac_valid) // [RULE9]
        else $error("offset word forwarded");
    a_pad_dropped: assert property (push_d && idx_r >= {8'h00, skip_r} && rel >= dw_r |=> !mac_valid) // [RULE11]
        else $error("alignment padding forwarded");
    a_b_only_fs: assert property (push_a && !a_fs |=> state_r != txp_pkg::P_CMD_B) // [RULE20]
        else $error("second word expected without first segment");
    a_apb_answer: assert property (access && !pready && !pwrite |=> pready)
        else $error("read not answered after one wait state");
endmodule // tx_buffer_command_parser

// ---- test/mac_sink_model.sv ----
// MAC-side sink model: takes words, with optional stalls, and keeps the bytes.
// Assumes the parser drives a registered valid, data word and lane mask.
`timescale 1ns/1ps
module mac_sink_model (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // Stall control from the bench
    input  wire logic        stall,
    // MAC transmit path
    input  wire logic        mac_valid,
    input  wire logic [31:0] mac_data,
    input  wire logic [3:0]  mac_lanes,
    input  wire logic        mac_sof,
    input  wire logic        mac_eof,
    output logic             mac_ready
);
    logic [7:0] got[$];
    int         sofs;
    int         eofs;
    int         cyc;

    initial begin
        mac_ready = 1'b0;
        sofs = 0;
        eofs = 0;
        cyc = 0;
    end

    // Ready only one cycle in three while stalling, to back-pressure the host port
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        mac_ready <= !srst && (!stall || (cyc % 3 == 0));
        if (!srst && mac_valid === 1'b1 && mac_ready) begin
            for (int l = 0; l < 4; l++) begin
                if (mac_lanes[l] === 1'b1) got.push_back(mac_data[8*l +: 8]);
            end
            sofs <= sofs + int'(mac_sof === 1'b1);
            eofs <= eofs + int'(mac_eof === 1'b1);
        end
    end
endmodule // mac_sink_model

// ---- test/test_tx_buffer_command_parser.sv ----
// Self-checking bench for the transmit buffer parser, host side over APB.
// Assumes the MAC sink model and one 100 MHz clock.
`timescale 1ns/1ps
module test_tx_buffer_command_parser;
    logic        core_clk, srst, psel, penable, pwrite, stall;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, status_word, mac_data, last_st, rd;
    logic        pready, pslverr, mac_ready, mac_valid, mac_sof, mac_eof, err;
    logic        frame_crc_add, frame_pad_en, frame_csum_en, status_valid;
    logic [3:0]  mac_lanes;
    logic [7:0]  exp[$];
    int          mismatches, compares, stat_cnt;
    typedef struct {logic [4:0] off; logic [10:0] size; logic [1:0] al; logic [31:0] b, st; logic [2:0] ctl;} row_t;
    row_t rows[4] = '{
        '{5'h01, 11'h005, 2'h0, 32'hA5A5_4005, 32'hA5A5_0000, 3'h7},
        '{5'h07, 11'h04F, 2'h1, 32'h1234_204F, 32'h1234_0000, 3'h2},
        '{5'h1F, 11'h011, 2'h2, 32'hBEEF_3012, 32'hBEEF_8000, 3'h4},
        '{5'h02, 11'h0B7, 2'h3, 32'h0042_10B7, 32'h0042_0000, 3'h4}};

    tx_buffer_command_parser uut (.core_clk(core_clk), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mac_ready(mac_ready), .mac_valid(mac_valid), .mac_data(mac_data), .mac_lanes(mac_lanes),
        .mac_sof(mac_sof), .mac_eof(mac_eof), .frame_crc_add(frame_crc_add), .frame_pad_en(frame_pad_en),
        .frame_csum_en(frame_csum_en), .status_word(status_word), .status_valid(status_valid));
    mac_sink_model mac (.core_clk(core_clk), .srst(srst), .stall(stall), .mac_valid(mac_valid),
        .mac_data(mac_data), .mac_lanes(mac_lanes), .mac_sof(mac_sof), .mac_eof(mac_eof), .mac_ready(mac_ready));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Status pulses stand one cycle, so latch them at their edge
    always @(posedge core_clk) begin
        if (status_valid === 1'b1) begin
            stat_cnt <= stat_cnt + 1;
            last_st <= status_word;
        end
    end

    task automatic tally_and_finish();
        if (mismatches == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    // Byte stream seen by the MAC against the payload bytes sent
    task automatic chk_stream();
        logic bad;
        // Last stored word may still sit in the stage while the MAC stalls
        for (int n = 0; n < 50 && mac_valid !== 1'b0; n++) @(posedge core_clk);
        bad = mac.got.size() != exp.size();
        foreach (exp[i]) if (i < mac.got.size() && mac.got[i] !== exp[i]) bad = 1'b1;
        compares++;
        if (bad) begin
            mismatches++;
            $display("unexpected at %0t: MAC byte stream differs", $time);
        end
        mac.got.delete();
        exp.delete();
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 400);
        if (n >= 400) begin
            mismatches++;
            tally_and_finish();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wait_stat(input int target);
        int n;
        n = 0;
        while (stat_cnt < target && n < 600) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 600) begin
            mismatches++;
            tally_and_finish();
        end
    endtask

    // Host writes A, B on first segments, then padded data words; reserved bits zero
    task automatic send_buf(input logic [4:0] off, input logic [10:0] size, input logic [1:0] al,
                            input logic fs, input logic ls, input logic [31:0] b, input logic [7:0] s);
        int nb;
        int n;
        nb = (al == 2'h1) ? 16 : (al == 2'h2) ? 32 : 4;
        n = (size == 0) ? 0 : ((off + size + nb - 1) / nb) * nb / 4;
        apb(1'b1, 8'h00, {6'h00, al, 3'h0, off, 2'h0, fs, ls, 1'h0, size});
        if (fs) apb(1'b1, 8'h00, b);
        for (int w = 0; w < n; w++) begin
            apb(1'b1, 8'h00, {s + 8'(4*w+3), s + 8'(4*w+2), s + 8'(4*w+1), s + 8'(4*w)});
        end
        for (int p = off; p < off + size; p++) exp.push_back(s + 8'(p));
    endtask

    initial begin
        {psel, penable, pwrite, stall} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        {mismatches, compares, stat_cnt} = 0;
        srst = 1'b1;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        chk({29'h0, frame_crc_add, frame_pad_en, frame_csum_en}, 32'h6);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h04, 32'h1);
        // Single-buffer packets, start lanes 1, 2 and 3, every alignment code
        foreach (rows[k]) begin
            stall <= k[0];
            send_buf(rows[k].off, rows[k].size, rows[k].al, 1'b1, 1'b1, rows[k].b, 8'(16*k));
            wait_stat(k + 1);
            chk_stream();
            chk(last_st, rows[k].st);
            chk({29'h0, frame_crc_add, frame_pad_en, frame_csum_en}, {29'h0, rows[k].ctl});
            apb(1'b0, 8'h0C, 32'h0);
            chk(rd, rows[k].st);
        end
        // Error flag sticks until written one, then clears
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, 8'h08, 32'h1);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        // Three-buffer packet, engine off, MAC stalling; middle buffer of 15 bytes
        apb(1'b1, 8'h04, 32'h0);
        stall <= 1'b1;
        send_buf(5'd7, 11'd79, 2'h1, 1'b1, 1'b0, 32'h0111_406F, 8'h30);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h2);
        send_buf(5'd0, 11'd15, 2'h1, 1'b0, 1'b0, 32'h0, 8'h90);
        send_buf(5'd10, 11'd17, 2'h1, 1'b0, 1'b1, 32'h0, 8'hC0);
        wait_stat(5);
        chk_stream();
        chk(last_st, 32'h0111_0000);
        chk({31'h0, frame_csum_en}, 32'h0);
        chk(32'(mac.sofs) ^ 32'(mac.eofs << 8), 32'h0505);
        // Unmapped place and data-port read
        apb(1'b0, 8'h10, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        // Reset in mid-packet: packet dropped, parser back to first command word
        apb(1'b1, 8'h00, 32'h0000_2004);
        srst <= 1'b1;
        @(posedge core_clk);
        srst <= 1'b0;
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        send_buf(5'd0, 11'd4, 2'h0, 1'b1, 1'b1, 32'h5A5A_0004, 8'h10);
        wait_stat(6);
        chk_stream();
        chk(last_st, 32'h5A5A_0000);
        tally_and_finish();
    end
endmodule // test_tx_buffer_command_parser
